// ---- rtl/prl_pkg.sv ----
// constants, types and layout for the per-port priority rate limiter
// How it works
// [R01] Port ingress priority 3 shaped by bits 7:4 of its ingress rate register.
// [R02] Port ingress priority 2 shaped by bits 3:0 of its ingress rate register.
// [R03] Port egress priority 1 shaped by bits 7:4 of its egress rate register.
// [R04] Port egress priority 0 shaped by bits 3:0 of its egress rate register.
// [R05] Code zero means no limit; every rate field resets to zero.
// [R06] Codes 1 to 15 select 64 Kbps up to 88 Mbps per the table.
// [R07] On a 10 Mbps port, codes above 10 Mbps act as unlimited.
// [R08] With single transmit queue, egress limiting applies to priority 0 only.
// [R09] Each of three ports has its own pair of rate registers.
// [R10] Gap counting option adds twelve bytes per frame to the cost.
// [R11] Preamble counting option adds eight bytes per frame to the cost.
// [R12] Token bucket per priority; frames beyond the credit are held.
package prl_pkg;
   // register indexes; byte address is four times the index
   localparam logic [7:0] PRL_IDX_P1_IN = 8'h17;
   localparam logic [7:0] PRL_IDX_P1_OUT = 8'h18;
   localparam logic [7:0] PRL_IDX_P2_IN = 8'h27;
   localparam logic [7:0] PRL_IDX_P2_OUT = 8'h28;
   localparam logic [7:0] PRL_IDX_P3_IN = 8'h37;
   localparam logic [7:0] PRL_IDX_P3_OUT = 8'h38;
   localparam logic [7:0] PRL_IDX_CFG = 8'h40;
   localparam logic [7:0] PRL_IDX_STAT = 8'h41;
   // field positions
   localparam int PRL_HI_LSB = 4;
   localparam int PRL_LO_LSB = 0;
   localparam int PRL_CFG_PRE = 0;
   localparam int PRL_CFG_GAP = 1;
   localparam int PRL_CFG_MULTIQ = 2;
   localparam int PRL_CFG_10M_LSB = 4;
   // reset values
   localparam logic [7:0] PRL_RATE_RST = 8'h00;
   localparam logic [7:0] PRL_CFG_RST = 8'h04;
   // byte accounting
   localparam logic [11:0] PRL_GAP_BYTES = 12'h00c;
   localparam logic [11:0] PRL_PRE_BYTES = 12'h008;
   localparam logic [12:0] PRL_MBIT_PER_BYTE = 13'h1f40;
   localparam logic [16:0] PRL_10M_KBPS = 17'h02710;
   // timing
   localparam int PRL_CLK_NS = 8;
   localparam int PRL_TICK_NS = 1000;
   localparam int PRL_TICK_CYC = PRL_TICK_NS / PRL_CLK_NS;
   localparam int PRL_NBKT = 12;

   // one frame asking for credit; id = port*4 + {in3,in2,out1,out0}
   typedef struct packed {
      logic valid;
      logic [3:0] id;
      logic [10:0] len;
   } prl_req_t;

   typedef enum logic [1:0] {
      PRL_BUS_IDLE = 2'b01,
      PRL_BUS_READ = 2'b10
   } prl_bus_t;

   function automatic logic [16:0] prl_rate_kbps(input logic [3:0] c);
      logic [16:0] r;
      r = 17'h00000;
      case (c) // [R06]
         4'h1: r = 17'h00040;
         4'h2: r = 17'h00080;
         4'h3: r = 17'h00100;
         4'h4: r = 17'h00200;
         4'h5: r = 17'h003e8;
         4'h6: r = 17'h007d0;
         4'h7: r = 17'h00fa0;
         4'h8: r = 17'h01f40;
         4'h9: r = 17'h03e80;
         4'ha: r = 17'h07d00;
         4'hb: r = 17'h0bb80;
         4'hc: r = 17'h0fa00;
         4'hd: r = 17'h11940;
         4'he: r = 17'h13880;
         4'hf: r = 17'h157c0;
         default: r = 17'h00000; // [R05]
      endcase
      return r;
   endfunction
endpackage

// ---- rtl/prl_rate_limiter.sv ----
// ahb-lite register slave and token-bucket shaper for three ports
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module prl_rate_limiter import prl_pkg::*; #(
   parameter logic [24:0] CAP_MBIT = 25'h0fa0000
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire prl_req_t frame_req,
   output logic frame_ok,
   output logic frame_hold
);
   ////////////////////////////////////////////////////////////////////////
   // bus slave
   logic [7:0] in_q [3];
   logic [7:0] out_q [3];
   logic [7:0] cfg_q;
   logic [11:0] held_q;
   prl_bus_t bus_q;
   logic wr_pend_q;
   logic [7:0] idx_q;
   logic hreadyout_q;
   logic [31:0] hrdata_q;
   logic accept;

   assign accept = hsel & htrans[1] & hready;

   function automatic logic [31:0] read_reg(input logic [7:0] idx,
         input logic [7:0] cfg, input logic [11:0] held,
         input logic [23:0] inr, input logic [23:0] outr);
      logic [31:0] v;
      v = 32'h00000000;
      case (idx)
         PRL_IDX_P1_IN: v[7:0] = inr[7:0];
         PRL_IDX_P2_IN: v[7:0] = inr[15:8];
         PRL_IDX_P3_IN: v[7:0] = inr[23:16];
         PRL_IDX_P1_OUT: v[7:0] = outr[7:0];
         PRL_IDX_P2_OUT: v[7:0] = outr[15:8];
         PRL_IDX_P3_OUT: v[7:0] = outr[23:16];
         PRL_IDX_CFG: v[7:0] = cfg;
         PRL_IDX_STAT: v[11:0] = held;
         default: v = 32'h00000000;
      endcase
      return v;
   endfunction

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_q <= PRL_BUS_IDLE;
         hreadyout_q <= 1'b1;
         hrdata_q <= 32'h00000000;
         wr_pend_q <= 1'b0;
         idx_q <= 8'h00;
      end else begin
         if (accept) begin
            idx_q <= haddr[9:2];
         end
         wr_pend_q <= accept & hwrite;
         unique case (bus_q)
            PRL_BUS_IDLE: begin
               if (accept & ~hwrite) begin
                  bus_q <= PRL_BUS_READ;
                  hreadyout_q <= 1'b0;
               end
            end
            PRL_BUS_READ: begin
               bus_q <= PRL_BUS_IDLE;
               hreadyout_q <= 1'b1;
               hrdata_q <= read_reg(idx_q, cfg_q, held_q,
                  {in_q[2], in_q[1], in_q[0]},
                  {out_q[2], out_q[1], out_q[0]});
            end
         endcase
      end
   end

   // rate registers, one pair per port
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int p = 0; p < 3; p++) begin
            in_q[p] <= PRL_RATE_RST; // [R05]
            out_q[p] <= PRL_RATE_RST; // [R05]
         end
         cfg_q <= PRL_CFG_RST;
      end else if (wr_pend_q) begin
         case (idx_q) // [R09]
            PRL_IDX_P1_IN: in_q[0] <= hwdata[7:0];
            PRL_IDX_P2_IN: in_q[1] <= hwdata[7:0];
            PRL_IDX_P3_IN: in_q[2] <= hwdata[7:0];
            PRL_IDX_P1_OUT: out_q[0] <= hwdata[7:0];
            PRL_IDX_P2_OUT: out_q[1] <= hwdata[7:0];
            PRL_IDX_P3_OUT: out_q[2] <= hwdata[7:0];
            PRL_IDX_CFG: cfg_q <= {1'b0, hwdata[6:4], 1'b0, hwdata[2:0]};
            default: cfg_q <= cfg_q;
         endcase
      end
   end

   assign hreadyout = hreadyout_q;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;

   ////////////////////////////////////////////////////////////////////////
   // effective rate per bucket
   logic [16:0] eff_rate [PRL_NBKT];

   always_comb begin
      for (int b = 0; b < PRL_NBKT; b++) begin
         logic [3:0] code;
         logic [16:0] r;
         code = 4'h0;
         r = 17'h00000;
         unique case (b % 4)
            0: code = in_q[b / 4][PRL_HI_LSB +: 4]; // [R01]
            1: code = in_q[b / 4][PRL_LO_LSB +: 4]; // [R02]
            2: code = out_q[b / 4][PRL_HI_LSB +: 4]; // [R03]
            3: code = out_q[b / 4][PRL_LO_LSB +: 4]; // [R04]
         endcase
         r = prl_rate_kbps(code);
         if (cfg_q[PRL_CFG_10M_LSB + b / 4] && r > PRL_10M_KBPS) begin
            r = 17'h00000; // [R07]
         end
         if (b % 4 == 2 && !cfg_q[PRL_CFG_MULTIQ]) begin
            r = 17'h00000; // [R08]
         end
         eff_rate[b] = r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // token buckets, credit in millibits, refilled every microsecond
   logic [6:0] tick_cnt_q;
   logic tick;
   logic [24:0] credit_q [PRL_NBKT];
   logic [11:0] cost_bytes;
   logic [24:0] cost;
   logic req_ok;
   logic bkt_valid;
   logic limited;

   assign tick = (tick_cnt_q == 7'(PRL_TICK_CYC - 1));
   assign bkt_valid = frame_req.valid && frame_req.id < 4'hc;
   assign cost_bytes = {1'b0, frame_req.len}
      + (cfg_q[PRL_CFG_GAP] ? PRL_GAP_BYTES : 12'h000) // [R10]
      + (cfg_q[PRL_CFG_PRE] ? PRL_PRE_BYTES : 12'h000); // [R11]
   assign cost = 25'(cost_bytes * PRL_MBIT_PER_BYTE);
   assign limited = bkt_valid && eff_rate[frame_req.id] != 17'h00000;
   assign req_ok = !limited || credit_q[frame_req.id] >= cost; // [R12]

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt_q <= 7'h00;
      end else begin
         tick_cnt_q <= tick ? 7'h00 : tick_cnt_q + 7'h01;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int b = 0; b < PRL_NBKT; b++) begin
            credit_q[b] <= CAP_MBIT;
         end
      end else begin
         for (int b = 0; b < PRL_NBKT; b++) begin
            logic [25:0] n;
            n = {1'b0, credit_q[b]};
            if (eff_rate[b] == 17'h00000) begin
               n = {1'b0, CAP_MBIT}; // [R05]
            end else begin
               if (tick) begin
                  n = n + {9'h000, eff_rate[b]}; // [R12]
               end
               if (limited && req_ok && frame_req.id == 4'(b)) begin
                  n = n - {1'b0, cost}; // [R12]
               end
               if (n > {1'b0, CAP_MBIT}) begin
                  n = {1'b0, CAP_MBIT};
               end
            end
            credit_q[b] <= n[24:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frame_ok <= 1'b0;
         frame_hold <= 1'b0;
         held_q <= 12'h000;
      end else begin
         frame_ok <= frame_req.valid & req_ok;
         frame_hold <= frame_req.valid & ~req_ok; // [R12]
         if (bkt_valid) begin
            held_q[frame_req.id] <= ~req_ok;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_read_wait;
      !hreadyout ##1 hreadyout;
   endsequence

   AST_READ_WAIT: assert property (
      bus_q == PRL_BUS_IDLE && accept && !hwrite |=> s_read_wait)
      else $error("read did not answer after one wait cycle");

   AST_IN3_FIELD: assert property ( // [R01]
      eff_rate[0] == (cfg_q[PRL_CFG_10M_LSB] && in_q[0][7:4] > 4'h8
      ? 17'h00000 : prl_rate_kbps(in_q[0][7:4])))
      else $error("port1 prio3 rate not taken from high nibble");

   AST_IN2_FIELD: assert property ( // [R02]
      cfg_q[PRL_CFG_10M_LSB + 1] == 1'b0
      |-> eff_rate[5] == prl_rate_kbps(in_q[1][3:0]))
      else $error("port2 prio2 rate not taken from low nibble");

   AST_OUT1_FIELD: assert property ( // [R03]
      cfg_q[PRL_CFG_MULTIQ] && !cfg_q[PRL_CFG_10M_LSB + 2]
      |-> eff_rate[10] == prl_rate_kbps(out_q[2][7:4]))
      else $error("port3 prio1 rate not taken from high nibble");

   AST_OUT0_FIELD: assert property ( // [R04]
      eff_rate[3] == 17'h00000 |-> out_q[0][3:0] == 4'h0
      || (cfg_q[PRL_CFG_10M_LSB] && out_q[0][3:0] > 4'h8))
      else $error("port1 prio0 unlimited without cause");

   AST_UNLIMITED_PASS: assert property ( // [R05]
      frame_req.valid && !limited |=> frame_ok && !frame_hold)
      else $error("unlimited frame was held");

   AST_SLOW_PORT: assert property ( // [R07]
      bkt_valid && cfg_q[PRL_CFG_10M_LSB + frame_req.id[3:2]]
      && eff_rate[frame_req.id] > PRL_10M_KBPS |-> 1'b0)
      else $error("rate above 10 Mbps kept on slow port");

   AST_SINGLE_QUEUE: assert property ( // [R08]
      bkt_valid && frame_req.id[1:0] == 2'b10 && !cfg_q[PRL_CFG_MULTIQ]
      |=> frame_ok)
      else $error("priority 1 egress limited with one queue");

   AST_PORT_COPY: assert property ( // [R09]
      wr_pend_q && idx_q == PRL_IDX_P2_IN |=> $stable(in_q[0])
      && in_q[1] == $past(hwdata[7:0]))
      else $error("port2 write leaked into port1");

   AST_HOLD_SHORT: assert property ( // [R12]
      limited && credit_q[frame_req.id] < cost
      |=> frame_hold && !frame_ok ##1 1'b1)
      else $error("frame passed without enough credit");

   AST_DEDUCT_COST: assert property ( // [R10] [R11]
      limited && req_ok && !tick && frame_req.id == 4'h3
      |=> credit_q[3] == $past(credit_q[3]) - 25'(($past(cost_bytes))
      * PRL_MBIT_PER_BYTE))
      else $error("credit not reduced by frame cost");

   AST_REFILL: assert property ( // [R06]
      tick && !frame_req.valid && eff_rate[0] != 17'h00000
      && credit_q[0] + 25'(eff_rate[0]) < CAP_MBIT
      |=> credit_q[0] == $past(credit_q[0]) + 25'($past(eff_rate[0])))
      else $error("bucket not refilled at table rate");

   sequence s_p3_out_addr;
      accept && hwrite && haddr[9:2] == PRL_IDX_P3_OUT;
   endsequence

   AST_P3_OUT_WRITE: assert property ( // [R09]
      s_p3_out_addr |=> hreadyout ##1 out_q[2] == $past(hwdata[7:0])
      && $stable(out_q[1]))
      else $error("port3 egress write missing or leaked into port2");

   AST_RESET_OPEN: assert property ( // [R05]
      $rose(hresetn) |-> hreadyout && eff_rate[0] == 17'h00000
      && eff_rate[11] == 17'h00000 && !frame_ok && !frame_hold)
      else $error("rate fields not unlimited after reset");

   AST_GAP_BYTES: assert property ( // [R10]
      frame_req.valid && cfg_q[PRL_CFG_GAP] && !cfg_q[PRL_CFG_PRE]
      |-> cost_bytes == {1'b0, frame_req.len} + PRL_GAP_BYTES)
      else $error("gap bytes not added to frame cost");

   AST_PRE_BYTES: assert property ( // [R11]
      frame_req.valid && cfg_q[PRL_CFG_PRE] && !cfg_q[PRL_CFG_GAP]
      |-> cost_bytes == {1'b0, frame_req.len} + PRL_PRE_BYTES)
      else $error("preamble bytes not added to frame cost");

   AST_NO_EXTRA: assert property ( // [R10] [R11]
      frame_req.valid && !cfg_q[PRL_CFG_GAP] && !cfg_q[PRL_CFG_PRE]
      |-> cost_bytes == {1'b0, frame_req.len})
      else $error("extra bytes counted with both options off");

   AST_CREDIT_CAP: assert property ( // [R12]
      credit_q[0] <= CAP_MBIT && credit_q[11] <= CAP_MBIT)
      else $error("bucket credit above its cap");

endmodule // prl_rate_limiter

// ---- tb/prl_testbench.sv ----
// self-checking bench for the per-port priority rate limiter
`timescale 1ns/1ps
module testbench import prl_pkg::*;;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   prl_req_t frame_req = '0;
   logic frame_ok;
   logic frame_hold;
   int errors = 0;
   int n_compared = 0;
   int cyc = 0;
   int kbps[16] = '{0, 64, 128, 256, 512, 1000, 2000, 4000, 8000, 16000,
      32000, 48000, 64000, 72000, 80000, 88000};

   always #4 hclk = ~hclk;

   // cap of eight bytes keeps every drain and refill short
   prl_rate_limiter #(.CAP_MBIT(25'h0fa00)) uut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .frame_req(frame_req), .frame_ok(frame_ok),
      .frame_hold(frame_hold));

   task automatic finish_test;
      if (errors == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         finish_test();
      end
   end

   task automatic check(input string nm, input logic [31:0] got,
         input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic bus(input logic wr, input logic [7:0] idx,
         input logic [7:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {22'h0, idx, 2'b00};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
      check("hresp", {31'h0, hresp}, 32'h0);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, idx, d, q);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, idx, 8'h00, q);
      check("register", q, e);
   endtask

   task automatic ask(input int id, input int len, input logic ok);
      frame_req <= '{1'b1, 4'(id), 11'(len)};
      @(posedge hclk);
      frame_req <= '0;
      @(posedge hclk);
      check("frame", {30'h0, frame_ok, frame_hold}, {30'h0, ok, !ok});
   endtask

   function automatic logic [7:0] ridx(input int p, input int s);
      return PRL_IDX_P1_IN + 8'(16 * p) + 8'(s / 2);
   endfunction

   function automatic logic [7:0] fld(input int s, input logic [3:0] c);
      return (s % 2 == 0) ? {c, 4'h0} : {4'h0, c};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      for (int p = 0; p < 3; p++) begin
         rd(ridx(p, 0), 32'h0);
         rd(ridx(p, 2), 32'h0);
      end
      rd(PRL_IDX_CFG, 32'h4);
      for (int k = 0; k < 6; k++) begin
         wr(ridx(k / 2, (k % 2) * 2), 8'(8'h5a + k * 8'h13));
      end
      wr(8'h10, 8'hff);
      for (int k = 0; k < 6; k++) begin
         rd(ridx(k / 2, (k % 2) * 2), 32'(8'h5a + k * 8'h13));
         wr(ridx(k / 2, (k % 2) * 2), 8'h00);
      end
      rd(8'h10, 32'h0);
   endtask

   task automatic t_field(input int p, input int s);
      wr(ridx(p, s), fld(s, 4'h8));
      ask(p * 4 + s, 8, 1'b1);
      ask(p * 4 + s, 2, 1'b0);
      rd(PRL_IDX_STAT, 32'h1 << (p * 4 + s));
      ask(p * 4 + (s ^ 1), 8, 1'b1);
      ask(p * 4 + (s ^ 1), 8, 1'b1);
      repeat (260) @(posedge hclk);
      ask(p * 4 + s, 2, 1'b1);
      wr(ridx(p, s), 8'h00);
   endtask

   task automatic t_codes;
      int r;
      int lo;
      int hi;
      for (int c = 1; c < 16; c++) begin
         r = kbps[c];
         wr(ridx(0, 0), 8'h00);
         wr(ridx(0, 0), fld(0, 4'(c)));
         ask(0, 8, 1'b1);
         repeat (200) @(posedge hclk);
         hi = 2 * r / 8000 + 1;
         lo = (r / 8000 > 8) ? 8 : r / 8000;
         if (hi <= 8) ask(0, hi, 1'b0);
         if (lo > 0) ask(0, lo, 1'b1);
      end
      wr(ridx(0, 0), 8'h00);
   endtask

   task automatic t_modes;
      wr(PRL_IDX_CFG, 8'h14);
      wr(ridx(0, 0), 8'h98);
      wr(ridx(1, 0), 8'h90);
      ask(0, 8, 1'b1);
      ask(0, 8, 1'b1);
      ask(1, 8, 1'b1);
      ask(1, 2, 1'b0);
      ask(4, 8, 1'b1);
      ask(4, 3, 1'b0);
      wr(PRL_IDX_CFG, 8'h00);
      wr(ridx(0, 2), 8'h88);
      ask(2, 8, 1'b1);
      ask(2, 8, 1'b1);
      ask(3, 8, 1'b1);
      ask(3, 2, 1'b0);
      wr(ridx(0, 0), 8'hf0);
      wr(PRL_IDX_CFG, 8'h05);
      ask(0, 1, 1'b0);
      ask(0, 0, 1'b1);
      repeat (130) @(posedge hclk);
      wr(PRL_IDX_CFG, 8'h06);
      ask(0, 0, 1'b0);
      wr(PRL_IDX_CFG, 8'h04);
      ask(0, 8, 1'b1);
      ask(15, 2047, 1'b1);
   endtask

   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      for (int p = 0; p < 3; p++) begin
         for (int s = 0; s < 4; s++) begin
            t_field(p, s);
         end
      end
      t_codes();
      t_modes();
      finish_test();
   end
endmodule // testbench
